//--- du_pkg.sv
/*
 * Shared constants for the dual serial port block: port count,
 * frame layout, line levels, bit timing and engine states.
 * Assumes a 40 MHz core clock and a fixed bit rate chosen at build.
 */
package du_pkg;

	// ============================================================
	// Structure
	localparam int UART_NPORT     = 2;
	localparam int UART_DATA_BITS = 8;
	localparam int UART_STOP_BITS = 1;
	localparam int UART_FIFO_DEP  = 4;

	// ============================================================
	// Line levels
	localparam logic UART_MARK     = 1'b1;  // Idle line, stop bit
	localparam logic UART_SPACE    = 1'b0;  // Start bit
	localparam logic UART_RTS_IDLE = 1'b1;  // Request inactive
	localparam logic UART_CTS_IDLE = 1'b1;  // Peer not ready

	// ============================================================
	// Timing
	localparam int UART_CLK_HZ  = 40_000_000;
	localparam int UART_BAUD_HZ = 115_200;
	localparam int UART_BIT_CYC = UART_CLK_HZ / UART_BAUD_HZ;
	localparam int UART_MIN_CYC = 4;

	// ============================================================
	// Serial engine states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_START = 4'h2,
		ST_DATA  = 4'h4,
		ST_STOP  = 4'h8
	} du_state_t;

endpackage : du_pkg

//--- du_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes an asynchronous pin; the output follows once stages
 * two and three agree.
 */
`timescale 1ns/1ps

module du_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	// Pin and filtered level
	input  wire logic async_i,
	output logic      level_o
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// Stage one feeds stage two only
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r    <= RST_VAL;
			s2_r    <= RST_VAL;
			s3_r    <= RST_VAL;
			level_r <= RST_VAL;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end

	assign level_o = level_r;

endmodule : du_sync

//--- du_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; depth must be a power of two.
 */
`timescale 1ns/1ps

module du_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_n_i,
	// Fill side
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	// Drain side
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);

	localparam int AW = (D > 1) ? $clog2(D) : 1;

	if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
		$error("du_fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem_r [D];
	logic [AW:0]  wptr_r;
	logic [AW:0]  rptr_r;

	wire          full  = (wptr_r[AW] != rptr_r[AW]) &&
	                      (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
	wire          empty = (wptr_r == rptr_r);
	wire          push  = in_valid_i && !full;
	wire          pop   = out_ready_i && !empty;

	// Handshakes
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem_r[rptr_r[AW-1:0]];

	// Storage
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wptr_r[AW-1:0]] <= in_data_i;
		end
	end

	// Pointers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end

endmodule : du_fifo

//--- du_uart.sv
/*
 * Two identical asynchronous serial ports with modem handshake pins.
 * Each port: transmit FIFO, transmitter, receiver, clear-to-send
 * status and request-to-send drive, with internal loopback.
 * Assumes pins are asynchronous and user-side signals share core_clk_i.
 */
`timescale 1ns/1ps

// What this block does
// - After reset each transmit pin sits at logic 1 until a character goes out.
// - Each port shows the current clear-to-send level as a readable status, or its own rts_req_i level in loopback.
// - Each port pulls its request-to-send low to say it is ready for data.
// - Reset forces each request-to-send output to logic 1.
// - In loopback each request-to-send output is held at logic 1.
// - Each port takes received characters from its own receive pin, or from its own transmit line in loopback.
module du_uart
	import du_pkg::*;
#(
	parameter int DW      = UART_DATA_BITS,
	parameter int STOPS   = UART_STOP_BITS,
	parameter int FDEPTH  = UART_FIFO_DEP,
	parameter int BIT_CYC = UART_BIT_CYC
) (
	// Clock and reset
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_n_i,
	// Port a pins
	input  wire logic                         serial_in_port_a_i,
	output logic                              serial_out_port_a_o,
	input  wire logic                         peer_ready_in_a_n_i,
	output logic                              port_ready_out_a_n_o,
	// Port b pins
	input  wire logic                         serial_in_port_b_i,
	output logic                              serial_out_port_b_o,
	input  wire logic                         peer_ready_in_b_n_i,
	output logic                              port_ready_out_b_n_o,
	// Control, index 0 is port a
	input  wire logic [UART_NPORT-1:0]        loop_i,
	input  wire logic [UART_NPORT-1:0]        rts_req_i,
	// Transmit stream
	input  wire logic [UART_NPORT-1:0][DW-1:0] tx_data_i,
	input  wire logic [UART_NPORT-1:0]        tx_valid_i,
	output logic      [UART_NPORT-1:0]        tx_ready_o,
	output logic      [UART_NPORT-1:0]        tx_busy_o,
	// Receive stream
	output logic      [UART_NPORT-1:0][DW-1:0] rx_data_o,
	output logic      [UART_NPORT-1:0]        rx_valid_o,
	output logic      [UART_NPORT-1:0]        rx_frame_err_o,
	// Modem status, high while peer is ready, or while rts_req_i is set in loopback
	output logic      [UART_NPORT-1:0]        cts_stat_o
);

	// ============================================================
	// Parameter checks
	if (BIT_CYC < UART_MIN_CYC) begin : g_bad_bit
		$error("du_uart BIT_CYC too small");
	end
	if (DW < 5 || DW > 9) begin : g_bad_dw
		$error("du_uart DW must be 5 to 9");
	end
	if (STOPS < 1 || STOPS > 2) begin : g_bad_stop
		$error("du_uart STOPS must be 1 or 2");
	end

	localparam int CW = $clog2(BIT_CYC);
	localparam int BW = $clog2(DW + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] CNT_HALF = CW'(BIT_CYC / 2 - 1);
	localparam logic [BW-1:0] BIT_LAST = BW'(DW - 1);
	localparam logic [BW-1:0] STOP_LAST = BW'(STOPS - 1);

	// ============================================================
	// Pin gathering
	// own receive pin
	wire [UART_NPORT-1:0] ser_in  = {serial_in_port_b_i, serial_in_port_a_i};
	wire [UART_NPORT-1:0] cts_pin = {peer_ready_in_b_n_i, peer_ready_in_a_n_i};
	logic [UART_NPORT-1:0] ser_out;
	logic [UART_NPORT-1:0] rts_out;

	assign serial_out_port_a_o  = ser_out[0];
	assign serial_out_port_b_o  = ser_out[1];
	assign port_ready_out_a_n_o = rts_out[0];
	assign port_ready_out_b_n_o = rts_out[1];

	// ============================================================
	// One serial port per pass
	for (genvar p = 0; p < UART_NPORT; p++) begin : g_port

		logic          rx_pin;
		logic          cts_n;
		logic [DW-1:0] f_data;
		logic          f_valid;
		logic          f_pop;

		du_sync #(
			.RST_VAL (UART_CTS_IDLE)
		) u_cts_sync (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.async_i    (cts_pin[p]),
			.level_o    (cts_n)
		);

		du_sync #(
			.RST_VAL (UART_MARK)
		) u_rx_sync (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.async_i    (ser_in[p]),
			.level_o    (rx_pin)
		);

		// Transmit buffer, stalls the writer when full
		du_fifo #(
			.W (DW),
			.D (FDEPTH)
		) u_tx_fifo (
			.core_clk_i  (core_clk_i),
			.rst_n_i     (rst_n_i),
			.in_data_i   (tx_data_i[p]),
			.in_valid_i  (tx_valid_i[p]),
			.in_ready_o  (tx_ready_o[p]),
			.out_data_o  (f_data),
			.out_valid_o (f_valid),
			.out_ready_i (f_pop)
		);

		// ========================================================
		// Transmitter
		du_state_t     tx_st_r,   tx_st_nxt;
		logic [CW-1:0] tx_cnt_r,  tx_cnt_nxt;
		logic [BW-1:0] tx_bit_r,  tx_bit_nxt;
		logic [DW-1:0] tx_sh_r,   tx_sh_nxt;
		logic          tx_line_r, tx_line_nxt;
		logic          tx_pin_r;
		logic          rts_r;
		logic          cts_r;

		wire tx_tick = (tx_cnt_r == '0);
		assign f_pop = (tx_st_r == ST_IDLE);

		always_comb begin
			tx_st_nxt   = tx_st_r;
			tx_cnt_nxt  = tx_tick ? CNT_FULL : tx_cnt_r - 1'b1;
			tx_bit_nxt  = tx_bit_r;
			tx_sh_nxt   = tx_sh_r;
			tx_line_nxt = tx_line_r;
			case (tx_st_r)
				ST_IDLE: begin
					tx_cnt_nxt = CNT_FULL;
					if (f_valid) begin
						tx_sh_nxt   = f_data;
						tx_line_nxt = UART_SPACE;
						tx_st_nxt   = ST_START;
					end
				end
				ST_START: begin
					if (tx_tick) begin
						tx_line_nxt = tx_sh_r[0];
						tx_sh_nxt   = tx_sh_r >> 1;
						tx_bit_nxt  = '0;
						tx_st_nxt   = ST_DATA;
					end
				end
				ST_DATA: begin
					if (tx_tick && tx_bit_r == BIT_LAST) begin
						tx_line_nxt = UART_MARK;
						tx_bit_nxt  = '0;
						tx_st_nxt   = ST_STOP;
					end else if (tx_tick) begin
						tx_line_nxt = tx_sh_r[0];
						tx_sh_nxt   = tx_sh_r >> 1;
						tx_bit_nxt  = tx_bit_r + 1'b1;
					end
				end
				ST_STOP: begin
					if (tx_tick && tx_bit_r == STOP_LAST) begin
						tx_st_nxt = ST_IDLE;
					end else if (tx_tick) begin
						tx_bit_nxt = tx_bit_r + 1'b1;
					end
				end
				default: begin
					tx_line_nxt = UART_MARK;
					tx_st_nxt   = ST_IDLE;
				end
			endcase
		end

		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				tx_st_r   <= ST_IDLE;
				tx_cnt_r  <= '0;
				tx_bit_r  <= '0;
				tx_sh_r   <= '0;
				tx_line_r <= UART_MARK;
			end else begin
				tx_st_r   <= tx_st_nxt;
				tx_cnt_r  <= tx_cnt_nxt;
				tx_bit_r  <= tx_bit_nxt;
				tx_sh_r   <= tx_sh_nxt;
				tx_line_r <= tx_line_nxt;
			end
		end

		// ========================================================
		// Pin drive and modem status
		// request inactive on reset
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				tx_pin_r <= UART_MARK;
				rts_r    <= UART_RTS_IDLE;
				cts_r    <= 1'b0;
			end else begin
				// Loopback keeps the line marking outside
				tx_pin_r <= loop_i[p] ? UART_MARK : tx_line_nxt;
				rts_r    <= (rts_req_i[p] && !loop_i[p]) ? !UART_RTS_IDLE
				                                         : UART_RTS_IDLE;
				cts_r    <= loop_i[p] ? rts_req_i[p] : !cts_n;
			end
		end

		assign ser_out[p]    = tx_pin_r;
		assign rts_out[p]    = rts_r;
		assign cts_stat_o[p] = cts_r;
		assign tx_busy_o[p]  = (tx_st_r != ST_IDLE) || f_valid;

		// ========================================================
		// Receiver
		du_state_t     rx_st_r,  rx_st_nxt;
		logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
		logic [BW-1:0] rx_bit_r, rx_bit_nxt;
		logic [DW-1:0] rx_sh_r,  rx_sh_nxt;
		logic [DW-1:0] rx_data_r;
		logic          rx_ok;
		logic          rx_bad;
		logic          rx_ok_r;
		logic          rx_bad_r;

		// Loopback feeds the transmit line straight back
		wire rx_line = loop_i[p] ? tx_line_r : rx_pin;
		wire rx_tick = (rx_cnt_r == '0);

		always_comb begin
			rx_st_nxt  = rx_st_r;
			rx_cnt_nxt = rx_tick ? CNT_FULL : rx_cnt_r - 1'b1;
			rx_bit_nxt = rx_bit_r;
			rx_sh_nxt  = rx_sh_r;
			rx_ok      = 1'b0;
			rx_bad     = 1'b0;
			case (rx_st_r)
				ST_IDLE: begin
					rx_cnt_nxt = CNT_HALF;
					if (rx_line == UART_SPACE) begin
						rx_st_nxt = ST_START;
					end
				end
				ST_START: begin
					if (rx_tick) begin
						rx_bit_nxt = '0;
						rx_st_nxt  = (rx_line == UART_SPACE) ? ST_DATA : ST_IDLE;
					end
				end
				ST_DATA: begin
					if (rx_tick) begin
						rx_sh_nxt  = {rx_line, rx_sh_r[DW-1:1]};
						rx_bit_nxt = rx_bit_r + 1'b1;
						if (rx_bit_r == BIT_LAST) begin
							rx_st_nxt = ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (rx_tick) begin
						rx_ok     = (rx_line == UART_MARK);
						rx_bad    = (rx_line != UART_MARK);
						rx_st_nxt = ST_IDLE;
					end
				end
				default: begin
					rx_st_nxt = ST_IDLE;
				end
			endcase
		end

		// Receiver state
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				rx_st_r  <= ST_IDLE;
				rx_cnt_r <= '0;
				rx_bit_r <= '0;
				rx_sh_r  <= '0;
			end else begin
				rx_st_r  <= rx_st_nxt;
				rx_cnt_r <= rx_cnt_nxt;
				rx_bit_r <= rx_bit_nxt;
				rx_sh_r  <= rx_sh_nxt;
			end
		end

		// Received word and one-cycle strobes
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				rx_data_r <= '0;
				rx_ok_r   <= 1'b0;
				rx_bad_r  <= 1'b0;
			end else begin
				rx_ok_r  <= rx_ok;
				rx_bad_r <= rx_bad;
				if (rx_ok || rx_bad) begin
					rx_data_r <= rx_sh_r;
				end
			end
		end

		assign rx_data_o[p]      = rx_data_r;
		assign rx_valid_o[p]     = rx_ok_r;
		assign rx_frame_err_o[p] = rx_bad_r;
	end

endmodule : du_uart

//--- du_uart_props.sv
/* Checker for the dual serial port pins.
 * Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps

module du_uart_props
	import du_pkg::*;
#(
	parameter int BIT_CYC = UART_BIT_CYC
) (
	// ========================================
	// Watched ports
	input wire logic                  core_clk_i,
	input wire logic                  rst_n_i,
	input wire logic                  serial_out_port_a_o,
	input wire logic                  port_ready_out_a_n_o,
	input wire logic                  port_ready_out_b_n_o,
	input wire logic                  peer_ready_in_a_n_i,
	input wire logic [UART_NPORT-1:0] loop_i,
	input wire logic [UART_NPORT-1:0] rts_req_i,
	input wire logic [UART_NPORT-1:0] tx_busy_o,
	input wire logic [UART_NPORT-1:0] rx_valid_o,
	input wire logic [UART_NPORT-1:0] rx_frame_err_o,
	input wire logic [UART_NPORT-1:0] cts_stat_o
);
	localparam int HB  = BIT_CYC - 1;
	localparam int STP = 8 * BIT_CYC + 1;
	localparam int FRM = 10 * BIT_CYC;
	int fc;

	// Cycle count within a port a frame, zero between frames
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) fc <= 0;
		else if (fc != 0) fc <= (fc == FRM - 1) ? 0 : fc + 1;
		else if (!serial_out_port_a_o) fc <= 1;
	end

	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_rst_idle: assert property ($rose(rst_n_i) |-> serial_out_port_a_o
		&& port_ready_out_a_n_o && port_ready_out_b_n_o) else $error("pins not idle");
	a_rts_a: assert property (!$rose(rst_n_i) |-> port_ready_out_a_n_o ==
		!($past(rts_req_i[0]) && !$past(loop_i[0]))) else $error("rts a wrong");
	a_rts_b: assert property (!$rose(rst_n_i) |-> port_ready_out_b_n_o ==
		!($past(rts_req_i[1]) && !$past(loop_i[1]))) else $error("rts b wrong");
	a_loop_mark: assert property (loop_i[0] |=> serial_out_port_a_o)
		else $error("tx not marking in loop");
	a_idle_mark: assert property (!tx_busy_o[0] [*2] |-> serial_out_port_a_o)
		else $error("tx not marking when idle");
	// start low a full bit, stop high
	a_frame_a: assert property (fc == HB |-> !serial_out_port_a_o)
		else $error("start bit too short");
	a_frame_stop: assert property (fc == HB + STP |-> serial_out_port_a_o)
		else $error("stop bit not high");
	a_cts_seen: assert property ((!loop_i[0] && $stable(peer_ready_in_a_n_i)) [*8]
		|-> cts_stat_o[0] == !peer_ready_in_a_n_i) else $error("cts status wrong");
	a_cts_loop: assert property ((loop_i[0] && $stable(rts_req_i[0])) [*3]
		|-> cts_stat_o[0] == rts_req_i[0]) else $error("loop status wrong");
	a_rx_pulse: assert property (rx_valid_o[0] |=> !rx_valid_o[0])
		else $error("rx strobe too long");
	a_rx_excl: assert property (!(rx_valid_o[1] && rx_frame_err_o[1]))
		else $error("rx strobes together");

	// Main scenarios reached
	c_loop: cover property (loop_i[0] && rts_req_i[0]);
	c_ferr: cover property (rx_frame_err_o[1]);
	c_start: cover property (fc == 0 && !serial_out_port_a_o);
endmodule : du_uart_props

bind du_uart du_uart_props #(.BIT_CYC(BIT_CYC)) du_uart_props_i (.core_clk_i, .rst_n_i,
	.serial_out_port_a_o, .port_ready_out_a_n_o, .port_ready_out_b_n_o,
	.peer_ready_in_a_n_i, .loop_i, .rts_req_i, .tx_busy_o, .rx_valid_o,
	.rx_frame_err_o, .cts_stat_o);

//--- du_peer.sv
/* Serial peer on both ports: sends and decodes frames, drives ready.
 * Assumes callers act just after a rising clock edge. */
`timescale 1ns/1ps

module du_peer
	import du_pkg::*;
#(
	parameter int BC = 8
) (
	// ========================================
	// Pins
	input  wire logic                  core_clk_i,
	input  wire logic [UART_NPORT-1:0] line_i,
	output logic      [UART_NPORT-1:0] line_o,
	output logic      [UART_NPORT-1:0] ready_n_o
);
	logic [UART_NPORT-1:0] rdy = '0;

	assign ready_n_o = ~rdy;
	initial line_o = '1;

	task tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask : tick

	task send(input int p, input logic [7:0] d, input logic stp);
		line_o[p] = UART_SPACE;
		tick(BC);
		for (int i = 0; i < 8; i++) begin
			line_o[p] = d[i];
			tick(BC);
		end
		line_o[p] = stp;
		tick(BC);
		line_o[p] = UART_MARK;
	endtask : send

	task get(input int p, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 4000 && line_i[p]; i++) tick(1);
		if (line_i[p]) return;
		tick(BC / 2);
		for (int i = 0; i < 8; i++) begin
			tick(BC);
			d[i] = line_i[p];
		end
		tick(BC);
		ok = line_i[p];
	endtask : get
endmodule : du_peer

//--- tb_top.sv
/* Self-checking bench for du_uart with a serial peer.
 * Assumes a small bit period to keep the run short. */
`timescale 1ns/1ps

module tb_top
	import du_pkg::*;
;
	localparam int BC = 8;
	typedef struct {int p; logic [7:0] d; logic stp; logic ev; logic ee;} du_row_t;
	logic                                     clk, rst_n;
	logic [UART_NPORT-1:0]                    loop, req, tx_valid, tx_ready, tx_busy;
	logic [UART_NPORT-1:0]                    rx_valid, rx_err, cts, ser_tx, ser_rx;
	logic [UART_NPORT-1:0]                    cts_n, rts_n;
	logic [UART_NPORT-1:0][UART_DATA_BITS-1:0] tx_data, rx_data;
	logic [7:0]                               got;
	bit                                       ok;
	int                                       error_cnt, checked, n;
	du_row_t rows[4] = '{'{0, 8'hA5, 1'b1, 1'b1, 1'b0}, '{1, 8'h3C, 1'b1, 1'b1, 1'b0},
		'{0, 8'h00, 1'b0, 1'b0, 1'b1}, '{1, 8'hFF, 1'b0, 1'b0, 1'b1}};
	du_row_t r;

	du_uart #(.BIT_CYC(BC)) du_uart_i (.core_clk_i(clk), .rst_n_i(rst_n),
		.serial_in_port_a_i(ser_rx[0]), .serial_out_port_a_o(ser_tx[0]),
		.peer_ready_in_a_n_i(cts_n[0]), .port_ready_out_a_n_o(rts_n[0]),
		.serial_in_port_b_i(ser_rx[1]), .serial_out_port_b_o(ser_tx[1]),
		.peer_ready_in_b_n_i(cts_n[1]), .port_ready_out_b_n_o(rts_n[1]),
		.loop_i(loop), .rts_req_i(req), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .tx_busy_o(tx_busy), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_frame_err_o(rx_err), .cts_stat_o(cts));
	du_peer #(.BC(BC)) du_peer_i (.core_clk_i(clk), .line_i(ser_tx), .line_o(ser_rx),
		.ready_n_o(cts_n));

	// ========================================
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	task give_verdict;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task tmo(input bit hit);
		if (!hit) begin
			error_cnt++;
			$display("Error wait ran out");
			give_verdict();
		end
	endtask : tmo

	task push(input int p, input logic [7:0] d);
		int i;
		tx_data[p] = d;
		tx_valid[p] = 1'b1;
		for (i = 0; i < 50 && !tx_ready[p]; i++) tick(1);
		tmo(i < 50);
		tick(1);
		tx_valid[p] = 1'b0;
	endtask : push

	task wstrobe(input int p);
		int i;
		for (i = 0; i < 200 && !(rx_valid[p] || rx_err[p]); i++) tick(1);
		tmo(i < 200);
	endtask : wstrobe

	// ========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{loop, req, tx_valid, tx_data} = '0;
		tick(12);
		rst_n = 1'b1;
		tick(2);
		foreach (rows[k]) begin
			r = rows[k];
			push(r.p, r.d);
			du_peer_i.get(r.p, got, ok);
			tmo(ok);
			chk("tx word", r.d, got);
			du_peer_i.send(r.p, r.d, r.stp);
			wstrobe(r.p);
			chk("rx valid", r.ev, rx_valid[r.p]);
			chk("rx err", r.ee, rx_err[r.p]);
			chk("rx word", r.d, rx_data[r.p]);
			tick(2 * BC);
		end
		$display("test rows done");
		req = 2'b11;
		tick(2);
		chk("rts a", 8'h00, rts_n[0]);
		loop = 2'b11;
		push(0, 8'h5A);
		wstrobe(0);
		chk("loop word", 8'h5A, rx_data[0]);
		chk("rts loop", 8'h01, rts_n[0]);
		chk("rts loop b", 8'h01, rts_n[1]);
		chk("cts loop b", 8'h01, cts[1]);
		chk("tx loop", 8'h01, ser_tx[0]);
		chk("cts loop", 8'h01, cts[0]);
		loop = 2'b00;
		du_peer_i.rdy = 2'b10;
		tick(10);
		chk("rts b", 8'h00, rts_n[1]);
		chk("cts a", 8'h00, cts[0]);
		chk("cts b", 8'h01, cts[1]);
		$display("test modem done");
		n = 0;
		fork
			begin
				tx_valid[1] = 1'b1;
				for (int i = 0; i < 8 && tx_ready[1]; i++) begin
					tx_data[1] = 8'h10 + i[7:0];
					tick(1);
					n++;
				end
				tx_valid[1] = 1'b0;
				chk("fifo full", 8'h00, tx_ready[1]);
				chk("fifo depth", 8'h01, n >= UART_FIFO_DEP);
			end
			for (int j = 0; j == 0 || j < n; j++) begin
				du_peer_i.get(1, got, ok);
				tmo(ok);
				chk("fifo word", 8'h10 + j[7:0], got);
			end
		join
		tick(BC);
		chk("drained", 8'h00, tx_busy[1]);
		$display("test fifo done");
		push(0, 8'hC3);
		tick(3 * BC);
		rst_n = 1'b0;
		#1;
		chk("tx reset", 8'h01, ser_tx[0]);
		chk("rts reset", 8'h01, rts_n[0]);
		tick(2);
		rst_n = 1'b1;
		tick(2);
		chk("busy reset", 8'h00, tx_busy[0]);
		$display("test reset done");
		give_verdict();
	end
endmodule : tb_top
